// >>> poer_pkg.sv
// Purpose: constants for the restart sequencer
// Assumes: core clock of 25 MHz
// Notes:   timer set periods are derived from millisecond figures
package poer_pkg;

  // ==========================================================
  // clock and time
  localparam int unsigned CLK_KHZ        = 25000;
  localparam int unsigned T_SET_LONG_MS  = 100;
  localparam int unsigned T_SET_SHORT_MS = 5;
  localparam int unsigned SET_LONG_CYC   = T_SET_LONG_MS * CLK_KHZ;
  localparam int unsigned SET_SHORT_CYC  = T_SET_SHORT_MS * CLK_KHZ;

  // ==========================================================
  // widths
  localparam int unsigned TDIV_W  = 22;
  localparam int unsigned TMODE_W = 4;

  // ==========================================================
  // timer mode selection field
  localparam logic [TMODE_W-1:0] TMODE_INIT = 4'h0;
  localparam int unsigned        TMODE_SHORT_BIT = 0;

  // ==========================================================
  // reset values
  localparam logic [TDIV_W-1:0] TDIV_ZERO = 22'h00_0000;
  localparam logic              BIT_CLR   = 1'b0;
  localparam logic              BIT_SET   = 1'b1;

  // ==========================================================
  // sequencer states
  typedef enum logic [1:0]
  {
    POER_RUN,
    POER_STOPPED,
    POER_WAKE,
    POER_POWER
  } poer_state_e;

endpackage

// >>> poer_restart.sv
// Purpose: restart sequencer for supply-low, chip-enable and clock-stop
// Assumes: all inputs synchronous to core_clk except ce_pin
// Notes:   oscillator stop is modelled by osc_run; the block keeps clocking
//          a mode write lands at the next divider reload, not at once
//          stop is ignored while the synced enable is high
`timescale 1ns/10ps

module poer_restart
#(
  parameter int unsigned SET_LONG_CYC  = poer_pkg::SET_LONG_CYC,
  parameter int unsigned SET_SHORT_CYC = poer_pkg::SET_SHORT_CYC
)
(
  input  wire logic                          core_clk,
  input  wire logic                          srst,
  input  wire logic                          supply_low_flag,
  input  wire logic                          ce_pin,
  input  wire logic                          stop_exec,
  input  wire logic                          tmode_wr,
  input  wire logic [poer_pkg::TMODE_W-1:0]  tmode_wdata,
  input  wire logic                          carry_rd,
  output logic                               halt_hold_clear,
  output logic                               ctrl_register_init,
  output logic                               core_init,
  output logic                               cpu_halt,
  output logic                               osc_run,
  output logic                               thr_low_sel,
  output logic                               timer_set_pulse,
  output logic                               timer_carry_flag,
  output logic [poer_pkg::TMODE_W-1:0]       timer_mode
);

  // ==========================================================
  // state
  typedef struct packed
  {
    logic                          ce_s1;
    logic                          ce_s2;
    logic                          ce_s3;
    poer_pkg::poer_state_e         st;
    logic [poer_pkg::TDIV_W-1:0]   tdiv;
    logic [poer_pkg::TMODE_W-1:0]  tmode;
    logic                          halt;
    logic                          ce_pend;
    logic                          carry_flag;
    logic                          carry_dis;
    logic                          hold;
    logic                          ctrl_init;
    logic                          core_init;
    logic                          osc;
    logic                          thr_low;
    logic                          set_pulse;
  } poer_regs_s;

  localparam logic [poer_pkg::TDIV_W-1:0] LONG_LOAD =
    poer_pkg::TDIV_W'(SET_LONG_CYC - 1);
  localparam logic [poer_pkg::TDIV_W-1:0] SHORT_LOAD =
    poer_pkg::TDIV_W'(SET_SHORT_CYC - 1);
  // half of the long period: first set pulse after wake lands mid-period
  localparam logic [poer_pkg::TDIV_W-1:0] HALF_LOAD =
    poer_pkg::TDIV_W'(SET_LONG_CYC / 2 - 1);

  // reset looks like a supply-low episode so the core starts held
  localparam poer_regs_s REGS_RST = '{
    ce_s1      : poer_pkg::BIT_CLR,
    ce_s2      : poer_pkg::BIT_CLR,
    ce_s3      : poer_pkg::BIT_CLR,
    st         : poer_pkg::POER_POWER,
    tdiv       : poer_pkg::TDIV_ZERO,
    tmode      : poer_pkg::TMODE_INIT,
    halt       : poer_pkg::BIT_SET,
    ce_pend    : poer_pkg::BIT_CLR,
    carry_flag : poer_pkg::BIT_CLR,
    carry_dis  : poer_pkg::BIT_SET,
    hold       : poer_pkg::BIT_SET,
    ctrl_init  : poer_pkg::BIT_SET,
    core_init  : poer_pkg::BIT_SET,
    osc        : poer_pkg::BIT_CLR,
    thr_low    : poer_pkg::BIT_CLR,
    set_pulse  : poer_pkg::BIT_CLR
  };

  poer_regs_s regs_ff;
  poer_regs_s nxt_regs;

  logic ce_rise;
  logic ce_high;
  logic tick;
  logic timer_on;
  logic stop_take;
  logic ce_fire;
  logic carry_set;
  logic mode_short;
  logic wake_go;

  // ==========================================================
  // edge detect on the synchronised copy only
  assign ce_high = regs_ff.ce_s2;
  assign ce_rise = regs_ff.ce_s2 & ~regs_ff.ce_s3;

  // timer counts only while the oscillator runs
  assign timer_on = (regs_ff.st == poer_pkg::POER_RUN) ||
                    (regs_ff.st == poer_pkg::POER_WAKE);
  assign tick = timer_on && (regs_ff.tdiv == poer_pkg::TDIV_ZERO);

  // ==========================================================
  // decoded events
  // stop is honoured only while the synced enable is low
  assign stop_take  = stop_exec && !ce_high;
  // a pending or fresh rise fires on the set pulse only
  assign ce_fire    = tick && (regs_ff.ce_pend || ce_rise);
  // set looks at the old disable bit, so set beats a same-cycle read
  assign carry_set  = tick && !regs_ff.carry_dis;
  assign mode_short = regs_ff.tmode[poer_pkg::TMODE_SHORT_BIT];
  assign wake_go    = ce_rise;

  // ==========================================================
  // next state
  always_comb
  begin
    nxt_regs = regs_ff;
    nxt_regs.ce_s1     = ce_pin;
    nxt_regs.ce_s2     = regs_ff.ce_s1;
    nxt_regs.ce_s3     = regs_ff.ce_s2;
    nxt_regs.set_pulse = poer_pkg::BIT_CLR;
    nxt_regs.core_init = poer_pkg::BIT_CLR;

    // ==========================================================
    // set period divider, period picked by the mode field
    // a mode write is seen only at the next reload
    if (timer_on)
    begin
      if (tick)
      begin
        nxt_regs.set_pulse = poer_pkg::BIT_SET;
        if (mode_short)
        begin
          nxt_regs.tdiv = SHORT_LOAD;
        end
        else
        begin
          nxt_regs.tdiv = LONG_LOAD;
        end
      end
      else
      begin
        nxt_regs.tdiv = regs_ff.tdiv - poer_pkg::TDIV_W'(1);
      end
    end

    // ==========================================================
    // carry flag and its disable
    // read clears first so that a same-cycle set survives
    if (carry_rd)
    begin
      nxt_regs.carry_flag = poer_pkg::BIT_CLR;
      nxt_regs.carry_dis  = poer_pkg::BIT_CLR;
    end
    if (carry_set)
    begin
      nxt_regs.carry_flag = poer_pkg::BIT_SET;
    end

    // ==========================================================
    // sequencer
    case (regs_ff.st)
      poer_pkg::POER_RUN:
      begin
        nxt_regs.hold      = poer_pkg::BIT_CLR;
        nxt_regs.ctrl_init = poer_pkg::BIT_CLR;
        nxt_regs.osc       = poer_pkg::BIT_SET;
        nxt_regs.thr_low   = poer_pkg::BIT_CLR;
        if (tmode_wr)
        begin
          nxt_regs.tmode = tmode_wdata;
        end
        // stop is a no-op while enable is high
        if (stop_take)
        begin
          nxt_regs.st        = poer_pkg::POER_STOPPED;
          nxt_regs.hold      = poer_pkg::BIT_SET;
          nxt_regs.ctrl_init = poer_pkg::BIT_SET;
          nxt_regs.core_init = poer_pkg::BIT_SET;
          nxt_regs.tmode     = poer_pkg::TMODE_INIT;
          nxt_regs.osc       = poer_pkg::BIT_CLR;
          nxt_regs.thr_low   = poer_pkg::BIT_SET;
          nxt_regs.halt      = poer_pkg::BIT_SET;
          nxt_regs.ce_pend   = poer_pkg::BIT_CLR;
        end
        else
        begin
          // halt is not touched: the program keeps running
          if (ce_rise)
          begin
            nxt_regs.ce_pend = poer_pkg::BIT_SET;
          end
          if (ce_fire)
          begin
            nxt_regs.core_init = poer_pkg::BIT_SET;
            nxt_regs.ce_pend   = poer_pkg::BIT_CLR;
          end
        end
      end

      poer_pkg::POER_STOPPED:
      begin
        nxt_regs.core_init = poer_pkg::BIT_SET;
        // hold blocks any halt release while enable stays low
        nxt_regs.hold      = poer_pkg::BIT_SET;
        // control init stands until the enable rises; low threshold stands until the first set pulse after wake
        nxt_regs.ctrl_init = poer_pkg::BIT_SET;
        nxt_regs.osc       = poer_pkg::BIT_CLR;
        nxt_regs.thr_low   = poer_pkg::BIT_SET;
        nxt_regs.halt      = poer_pkg::BIT_SET;
        if (wake_go)
        begin
          nxt_regs.st        = poer_pkg::POER_WAKE;
          nxt_regs.osc       = poer_pkg::BIT_SET;
          nxt_regs.hold      = poer_pkg::BIT_CLR;
          nxt_regs.ctrl_init = poer_pkg::BIT_CLR;
          nxt_regs.core_init = poer_pkg::BIT_CLR;
          nxt_regs.tdiv      = HALF_LOAD;
        end
      end

      poer_pkg::POER_WAKE:
      begin
        nxt_regs.hold      = poer_pkg::BIT_CLR;
        nxt_regs.ctrl_init = poer_pkg::BIT_CLR;
        if (tick)
        begin
          nxt_regs.halt    = poer_pkg::BIT_CLR;
          nxt_regs.thr_low = poer_pkg::BIT_CLR;
          nxt_regs.st      = poer_pkg::POER_RUN;
        end
        else
        begin
          // program stays halted until the set pulse
          nxt_regs.halt    = poer_pkg::BIT_SET;
        end
      end

      poer_pkg::POER_POWER:
      begin
        if (!supply_low_flag)
        begin
          nxt_regs.st        = poer_pkg::POER_WAKE;
          nxt_regs.osc       = poer_pkg::BIT_SET;
          nxt_regs.hold      = poer_pkg::BIT_CLR;
          nxt_regs.ctrl_init = poer_pkg::BIT_CLR;
          nxt_regs.core_init = poer_pkg::BIT_CLR;
          nxt_regs.thr_low   = poer_pkg::BIT_CLR;
          nxt_regs.tdiv      = HALF_LOAD;
        end
        else
        begin
          // still low: hold, both inits and halt stay asserted, oscillator stays off
          nxt_regs.hold      = poer_pkg::BIT_SET;
          nxt_regs.ctrl_init = poer_pkg::BIT_SET;
          nxt_regs.core_init = poer_pkg::BIT_SET;
          nxt_regs.halt      = poer_pkg::BIT_SET;
          nxt_regs.osc       = poer_pkg::BIT_CLR;
        end
      end

      default:
      begin
        nxt_regs.st = poer_pkg::POER_RUN;
      end
    endcase

    // ==========================================================
    // supply low overrides everything else
    if (supply_low_flag)
    begin
      nxt_regs.st         = poer_pkg::POER_POWER;
      nxt_regs.osc        = poer_pkg::BIT_CLR;
      nxt_regs.halt       = poer_pkg::BIT_SET;
      nxt_regs.hold       = poer_pkg::BIT_SET;
      nxt_regs.ctrl_init  = poer_pkg::BIT_SET;
      nxt_regs.core_init  = poer_pkg::BIT_SET;
      nxt_regs.tmode      = poer_pkg::TMODE_INIT;
      nxt_regs.ce_pend    = poer_pkg::BIT_CLR;
      nxt_regs.carry_dis  = poer_pkg::BIT_SET;
      nxt_regs.carry_flag = poer_pkg::BIT_CLR;
      nxt_regs.set_pulse  = poer_pkg::BIT_CLR;
      nxt_regs.tdiv       = poer_pkg::TDIV_ZERO;
      // threshold stays low if the drop came during stop
      nxt_regs.thr_low    = regs_ff.thr_low;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      regs_ff <= REGS_RST;
    end
    else
    begin
      regs_ff <= nxt_regs;
    end
  end

  // ==========================================================
  // outputs
  assign halt_hold_clear    = regs_ff.hold;
  assign ctrl_register_init = regs_ff.ctrl_init;
  assign core_init          = regs_ff.core_init;
  assign cpu_halt           = regs_ff.halt;
  assign osc_run            = regs_ff.osc;
  assign thr_low_sel        = regs_ff.thr_low;
  assign timer_set_pulse    = regs_ff.set_pulse;
  assign timer_carry_flag   = regs_ff.carry_flag;
  assign timer_mode         = regs_ff.tmode;

endmodule

// >>> poer_supply_model.sv
// Purpose: supply detector and chip-enable line beside the sequencer
// Assumes: vdd_mv in millivolts
// Notes:   outputs move only at rising edges
`timescale 1ns/10ps
module poer_supply_model
(
  input  wire logic        core_clk,
  input  wire logic        thr_low_sel,
  input  wire logic [15:0] vdd_mv,
  input  wire logic        ce_req,
  output logic             supply_low_flag = 1'b1,
  output logic             ce_pin = 1'b0
);
  // ==========================================================
  // detector with switched threshold
  always @(posedge core_clk)
  begin
    supply_low_flag <= vdd_mv < (thr_low_sel ? 16'h0898 : 16'h0dac);
    ce_pin          <= ce_req;
  end
endmodule

// >>> poer_restart_checker.sv
// Purpose: port assertions for the restart sequencer
// Assumes: synced enable lags the pin by two or three edges
// Notes:   wake delay counted in helper logic
`timescale 1ns/10ps
module poer_restart_checker
#(
  parameter int unsigned SET_LONG_CYC  = 40,
  parameter int unsigned SET_SHORT_CYC = 8
)
(
  input wire logic                         core_clk,
  input wire logic                         srst,
  input wire logic                         supply_low_flag,
  input wire logic                         ce_pin,
  input wire logic                         stop_exec,
  input wire logic                         tmode_wr,
  input wire logic [poer_pkg::TMODE_W-1:0] tmode_wdata,
  input wire logic                         carry_rd,
  input wire logic                         halt_hold_clear,
  input wire logic                         ctrl_register_init,
  input wire logic                         core_init,
  input wire logic                         cpu_halt,
  input wire logic                         osc_run,
  input wire logic                         thr_low_sel,
  input wire logic                         timer_set_pulse,
  input wire logic                         timer_carry_flag,
  input wire logic [poer_pkg::TMODE_W-1:0] timer_mode
);
  // ==========================================================
  // halted cycles since hold dropped
  int unsigned wake_cnt_ff;
  always_ff @(posedge core_clk)
    wake_cnt_ff <= (srst || halt_hold_clear) ? 0 : (cpu_halt ? wake_cnt_ff + 1 : wake_cnt_ff);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_all_held;
    halt_hold_clear && ctrl_register_init && core_init && cpu_halt && !osc_run;
  endsequence
  sequence s_stop_req;
    stop_exec && !ce_pin && !$past(ce_pin) && !$past(ce_pin, 2) && !$past(ce_pin, 3)
      && !cpu_halt && !halt_hold_clear && !supply_low_flag;
  endsequence
  // ==========================================================
  a_supply_low_all: assert property (supply_low_flag |=> s_all_held ##0 (timer_mode == 4'h0))
    else $error("supply low did not hold the core");
  a_halt_release: assert property ($fell(cpu_halt) |-> timer_set_pulse)
    else $error("halt left without set pulse");
  a_ce_init_sync: assert property (core_init && !halt_hold_clear |-> timer_set_pulse && !cpu_halt)
    else $error("enable restart off the set pulse");
  a_ce_init_single: assert property (core_init && !halt_hold_clear |=> !core_init)
    else $error("enable restart init too long");
  a_stop_enter: assert property (s_stop_req |=> s_all_held ##0 (thr_low_sel && timer_mode == 4'h0))
    else $error("stop did not assert all controls");
  a_stop_refused: assert property (stop_exec && $past(ce_pin, 2) && $past(ce_pin, 3) && !halt_hold_clear
    && !supply_low_flag |=> !halt_hold_clear)
    else $error("stop taken with enable high");
  a_stop_hold: assert property (halt_hold_clear && thr_low_sel && !ce_pin |=> halt_hold_clear)
    else $error("hold dropped while enable low");
  a_thr_from_stop: assert property ($rose(thr_low_sel) |-> $past(stop_exec))
    else $error("low threshold without stop");
  a_wake_half_delay: assert property ($fell(cpu_halt) |-> wake_cnt_ff == SET_LONG_CYC / 2)
    else $error("wake delay not half the long period");
endmodule
bind poer_restart poer_restart_checker #(.SET_LONG_CYC(SET_LONG_CYC), .SET_SHORT_CYC(SET_SHORT_CYC))
  i_poer_restart_checker (.core_clk(core_clk), .srst(srst), .supply_low_flag(supply_low_flag), .ce_pin(ce_pin),
  .stop_exec(stop_exec), .tmode_wr(tmode_wr), .tmode_wdata(tmode_wdata), .carry_rd(carry_rd),
  .halt_hold_clear(halt_hold_clear), .ctrl_register_init(ctrl_register_init), .core_init(core_init),
  .cpu_halt(cpu_halt), .osc_run(osc_run), .thr_low_sel(thr_low_sel), .timer_set_pulse(timer_set_pulse),
  .timer_carry_flag(timer_carry_flag), .timer_mode(timer_mode));

// >>> poer_restart_tb_top.sv
// Purpose: scenario testbench for the restart sequencer
// Assumes: short set periods for simulation
// Notes:   drive on rising edge, sample on falling edge
`timescale 1ns/10ps
module poer_restart_tb_top;
  localparam int unsigned LONG = 40;
  localparam int unsigned SHORT = 8;
  logic                         core_clk = 1'b0;
  logic                         srst = 1'b1;
  logic                         stop_exec = 1'b0;
  logic                         tmode_wr = 1'b0;
  logic                         carry_rd = 1'b0;
  logic                         ce_req = 1'b0;
  logic [poer_pkg::TMODE_W-1:0] tmode_wdata = 4'h0;
  logic [15:0]                  vdd_mv = 16'h0bb8;
  logic                         supply_low_flag, ce_pin, halt_hold_clear, ctrl_register_init, core_init;
  logic                         cpu_halt, osc_run, thr_low_sel, timer_set_pulse, timer_carry_flag;
  logic [poer_pkg::TMODE_W-1:0] timer_mode;
  int                           fail_count = 0;
  int                           compares = 0;
  int                           n;
  always #20 core_clk = ~core_clk;
  poer_restart #(.SET_LONG_CYC(LONG), .SET_SHORT_CYC(SHORT)) i_poer_restart (.core_clk(core_clk), .srst(srst),
    .supply_low_flag(supply_low_flag), .ce_pin(ce_pin), .stop_exec(stop_exec), .tmode_wr(tmode_wr),
    .tmode_wdata(tmode_wdata), .carry_rd(carry_rd), .halt_hold_clear(halt_hold_clear),
    .ctrl_register_init(ctrl_register_init), .core_init(core_init), .cpu_halt(cpu_halt), .osc_run(osc_run),
    .thr_low_sel(thr_low_sel), .timer_set_pulse(timer_set_pulse), .timer_carry_flag(timer_carry_flag),
    .timer_mode(timer_mode));
  poer_supply_model i_poer_supply_model (.core_clk(core_clk), .thr_low_sel(thr_low_sel), .vdd_mv(vdd_mv),
    .ce_req(ce_req), .supply_low_flag(supply_low_flag), .ce_pin(ce_pin));
  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // sel 0 set pulse, 1 core init, 2 halt released; bounded wait
  task automatic await(input int sel, output int cnt);
    cnt = 0;
    while (cnt < 300 && !(sel == 0 ? timer_set_pulse === 1'b1 : sel == 1 ? core_init === 1'b1 : cpu_halt === 1'b0))
    begin
      @(negedge core_clk);
      cnt++;
    end
    // a wait that runs out is a failure, never a silent pass
    if (cnt >= 300)
    begin
      fail_count++;
    end
  endtask
  task automatic stop_pulse;
    @(posedge core_clk) stop_exec <= 1'b1;
    @(posedge core_clk) stop_exec <= 1'b0;
    @(negedge core_clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_power_on;
    @(negedge core_clk) check({halt_hold_clear, ctrl_register_init, core_init, cpu_halt, osc_run}, 5'h1e);
    @(posedge core_clk) vdd_mv <= 16'h1388;
    @(posedge core_clk) srst <= 1'b0;
    await(2, n);
    check(timer_set_pulse, 1'b1);
    check({core_init, osc_run, timer_mode}, 6'h10);
  endtask
  task automatic t_carry;
    await(0, n);
    @(negedge core_clk) check(timer_carry_flag, 1'b0);
    @(posedge core_clk) carry_rd <= 1'b1;
    @(posedge core_clk) carry_rd <= 1'b0;
    await(0, n);
    @(negedge core_clk) check(timer_carry_flag, 1'b1);
  endtask
  task automatic t_ce_run;
    @(posedge core_clk) {tmode_wr, tmode_wdata} <= 5'h11;
    @(posedge core_clk) tmode_wr <= 1'b0;
    await(0, n);
    @(posedge core_clk) ce_req <= 1'b1;
    await(1, n);
    check(n >= 6 && n <= SHORT + 2, 1'b1);
    check({timer_set_pulse, cpu_halt, halt_hold_clear, ctrl_register_init}, 4'h8);
    check(timer_mode, 4'h1);
    stop_pulse();
    check({halt_hold_clear, cpu_halt}, 2'h0);
  endtask
  task automatic t_stop;
    @(posedge core_clk) ce_req <= 1'b0;
    repeat (5) @(posedge core_clk);
    stop_pulse();
    check({halt_hold_clear, ctrl_register_init, core_init, cpu_halt, thr_low_sel, osc_run}, 6'h3e);
    check(timer_mode, 4'h0);
    vdd_mv <= 16'h0bb8;
    repeat (10) @(negedge core_clk);
    check({supply_low_flag, halt_hold_clear}, 2'h1);
    @(posedge core_clk) {vdd_mv, ce_req} <= {16'h1388, 1'b1};
    await(2, n);
    check(n >= LONG / 2 && n <= LONG / 2 + 5, 1'b1);
    check({thr_low_sel, timer_mode}, 5'h00);
  endtask
  task automatic t_supply_low;
    @(posedge core_clk) {vdd_mv, ce_req} <= {16'h0bb8, 1'b0};
    repeat (4) @(posedge core_clk);
    ce_req <= 1'b1;
    @(negedge core_clk) check({halt_hold_clear, ctrl_register_init, core_init, cpu_halt, osc_run}, 5'h1e);
    @(posedge core_clk) vdd_mv <= 16'h1388;
    await(2, n);
    check(n >= LONG / 2 && n <= LONG / 2 + 4, 1'b1);
    check({core_init, timer_mode}, 5'h00);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (2) @(posedge core_clk);
    t_power_on();
    t_carry();
    t_ce_run();
    t_stop();
    t_supply_low();
    conclude();
  end
  initial
  begin
    #100000;
    fail_count++;
    conclude();
  end
endmodule
